// *** rtl/pmc_regs.svh ***
// Constants of the pluggable module control block
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// Power-on initialisation time and the core clock rate
`define PMC_INIT_MS 32'd2000
`define PMC_CLK_KHZ 32'd40000
// Default low time of the reset pin before a reset is taken, in core cycles
`define PMC_RST_MIN_CYC 16'h0028
// Synchroniser lanes in the core
`define PMC_SYN_SEL 0
`define PMC_SYN_RST 1
`define PMC_SYN_LPR 2
`define PMC_SYN_W 3
// Idle pin levels {low power, reset, select}: keeps a false power limit off after reset
`define PMC_SYN_IDLE 3'h3
`define PMC_NUM_CH 4

`endif

// *** rtl/pmc_pkg.sv ***
// Types of the pluggable module control block
package pmc_pkg;

    // Gray along INIT -> READY -> RESET; RESET -> INIT flips both bits
    typedef enum logic [1:0]
    {
        PMC_ST_INIT = 2'h0,
        PMC_ST_READY = 2'h1,
        PMC_ST_RESET = 2'h3
    } pmc_state_t;

    typedef struct packed
    {
        logic [2:0] sync1;
        logic [2:0] sync2;
        pmc_state_t state;
        logic [31:0] cnt;
        logic [15:0] rst_cnt;
        logic done_flag;
        logic fault_flag;
        logic init_pending;
        logic defaults_pulse;
        logic sel_ok;
        logic power_low;
        logic [3:0] ch_en;
    } pmc_core_t;

    typedef struct packed
    {
        logic sel_s1;
        logic sel_s2;
    } pmc_link_t;

endpackage

// *** rtl/pmc_if.sv ***
// Carrier between the core and the serial-clock gate
`timescale 1ns/1ps
interface pmc_if;
    logic sel_ok;
    modport core (output sel_ok);
    modport link (input sel_ok);
endinterface

// *** rtl/pmc_link.sv ***
// Serial-clock side gate of the two-wire data drive
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_link
(
    input wire logic scl,
    input wire logic nrst,
    pmc_if.link lk,
    input wire logic slave_sda_low,
    output logic sda_out,
    output logic sda_oe_n,
    output logic slave_enable
);

    pmc_pkg::pmc_link_t q;
    pmc_pkg::pmc_link_t d;

    // ----------------------------------------
    // Select crossing into the serial clock
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.sel_s1 = lk.sel_ok;
        d.sel_s2 = q.sel_s1;
    end

    always_ff @(posedge scl or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= d;
    end

    // Engine and data drive only live while selected
    // Serial clock stops between frames, so the gate may lag by two edges
    assign slave_enable = q.sel_s2; // RULE1
    assign sda_out = 1'b0;
    assign sda_oe_n = !(q.sel_s2 && slave_sda_low); // RULE1

    property p_sda_gate;
        @(posedge scl) disable iff (!nrst)
        !$past(lk.sel_ok, 2) |-> sda_oe_n;
    endproperty
    a_sda_gate: assert property (p_sda_gate) else $error("sda driven while unselected"); // RULE1

endmodule

// *** rtl/pmc_ctrl.sv ***
// Low-speed sideband control core of a four-lane pluggable module
// Rules for this block and its host
// RULE1: Answer serial bus only while selected
// RULE2: Host selects at most one module
// RULE3: Long reset pin low restores defaults
// RULE4: Host ignores status during reset
// RULE5: Completion: attention low, pending flag cleared
// RULE6: Power-up posts completion without reset pulse
// RULE7: Low power pin limits power class
// RULE8: Presence pin pulled low by module
// RULE9: Attention low on fault or critical status
// RULE10: Host reads status after attention
// RULE11: Attention is open drain, low only
// RULE12: Four channels, each host can disable
// RULE13: Seven low-speed control pins provided
// RULE14: Fully functional within 2000 ms
// RULE15: Reset pin synchronised and length qualified
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_ctrl
#(
    parameter int unsigned INIT_CYCLES = `PMC_INIT_MS * `PMC_CLK_KHZ,
    parameter logic [15:0] RST_MIN_CYCLES = `PMC_RST_MIN_CYC,
    parameter int NUM_CH = `PMC_NUM_CH
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic en,
    input wire logic scl,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic slave_sda_low,
    input wire logic [NUM_CH-1:0] channel_disable,
    input wire logic fault_event,
    input wire logic int_ack,
    output logic sda_out,
    output logic sda_oe_n,
    output logic slave_enable,
    output logic presence_n_out,
    output logic presence_n_oe_n,
    output logic attention_n_out,
    output logic attention_n_oe_n,
    output logic init_pending_flag,
    output logic defaults_restore,
    output logic power_limit_low,
    output logic [NUM_CH-1:0] tx_channel_enable
);

    localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);
    localparam logic [15:0] RST_LAST = 16'(RST_MIN_CYCLES - 16'h0001);

    pmc_pkg::pmc_core_t q;
    pmc_pkg::pmc_core_t d;
    pmc_if lk ();

    // ----------------------------------------
    // Next state of the core
    // ----------------------------------------
    always_comb
    begin
        d = q;
        d.defaults_pulse = 1'b0;
        // Pins are asynchronous to the core clock
        d.sync1 = {low_power_request, module_reset_n, module_select_n}; // RULE13
        d.sync2 = q.sync1;
        d.sel_ok = !q.sync2[`PMC_SYN_SEL]; // RULE1
        d.power_low = q.sync2[`PMC_SYN_LPR]; // RULE7
        // Length filter keeps glitches on the reset pin from wiping settings
        if (!q.sync2[`PMC_SYN_RST])
        begin
            if (q.rst_cnt != RST_LAST)
                d.rst_cnt = q.rst_cnt + 16'h0001; // RULE15
        end
        else
        begin
            d.rst_cnt = 16'h0000;
        end
        case (q.state)
            pmc_pkg::PMC_ST_INIT:
            begin
                d.ch_en = '0;
                d.cnt = q.cnt + 32'h0000_0001;
                if (q.cnt == INIT_LAST)
                begin
                    d.state = pmc_pkg::PMC_ST_READY; // RULE14
                    d.init_pending = 1'b0; // RULE5
                    d.done_flag = 1'b1; // RULE6
                end
            end
            pmc_pkg::PMC_ST_READY:
            begin
                d.ch_en = ~channel_disable; // RULE12
            end
            pmc_pkg::PMC_ST_RESET:
            begin
                d.ch_en = '0;
                d.cnt = 32'h0000_0000;
                if (q.sync2[`PMC_SYN_RST])
                    d.state = pmc_pkg::PMC_ST_INIT;
            end
            default:
            begin
                d.state = pmc_pkg::PMC_ST_RESET;
            end
        endcase
        // Qualified reset overrides everything and restores defaults
        if (!q.sync2[`PMC_SYN_RST] && q.rst_cnt == RST_LAST && q.state != pmc_pkg::PMC_ST_RESET)
        begin
            d.state = pmc_pkg::PMC_ST_RESET; // RULE3
            d.defaults_pulse = 1'b1; // RULE3
            d.init_pending = 1'b1; // RULE3
            d.done_flag = 1'b0;
            d.fault_flag = 1'b0;
            d.ch_en = '0;
        end
        else
        begin
            // Acknowledge clears, but a new event in the same cycle wins
            if (int_ack)
            begin
                d.fault_flag = 1'b0;
                if (q.state == pmc_pkg::PMC_ST_READY)
                    d.done_flag = 1'b0;
            end
            if (fault_event && q.state == pmc_pkg::PMC_ST_READY)
                d.fault_flag = 1'b1; // RULE9
            if (q.state == pmc_pkg::PMC_ST_INIT && q.cnt == INIT_LAST)
                d.done_flag = 1'b1; // RULE5
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            // Power-up starts in INIT, so completion posts by itself
            q <= '0; // RULE6
            q.init_pending <= 1'b1;
            q.sync1 <= `PMC_SYN_IDLE;
            q.sync2 <= `PMC_SYN_IDLE;
        end
        else if (en)
        begin
            q <= d;
        end
    end

    // Pin drivers: presence is a hard pull to ground
    assign presence_n_out = 1'b0; // RULE8
    assign presence_n_oe_n = 1'b0; // RULE8
    assign attention_n_out = 1'b0; // RULE11
    assign attention_n_oe_n = !(q.done_flag || q.fault_flag); // RULE9
    assign init_pending_flag = q.init_pending;
    assign defaults_restore = q.defaults_pulse;
    assign power_limit_low = q.power_low;
    assign tx_channel_enable = q.ch_en;
    assign lk.sel_ok = q.sel_ok;

    // Two-wire data gate on the serial clock
    pmc_link u_link
    (
        .scl(scl),
        .nrst(nrst),
        .lk(lk),
        .slave_sda_low(slave_sda_low),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .slave_enable(slave_enable)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_select;
        (!module_select_n && en) [*4] |-> q.sel_ok;
    endproperty
    a_select: assert property (p_select) else $error("select not seen"); // RULE1

    property p_reset;
        (en && d.defaults_pulse) |=> (q.state == pmc_pkg::PMC_ST_RESET && q.ch_en == '0);
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not clear"); // RULE3

    property p_done;
        $fell(init_pending_flag) |-> !attention_n_oe_n;
    endproperty
    a_done: assert property (p_done) else $error("completion not posted"); // RULE5

    property p_power_up;
        (en && q.state == pmc_pkg::PMC_ST_INIT && q.cnt == INIT_LAST && !d.defaults_pulse)
            |=> (q.done_flag && !init_pending_flag);
    endproperty
    a_power_up: assert property (p_power_up) else $error("init end missed"); // RULE6

    property p_lpr;
        (low_power_request && en) [*4] |-> power_limit_low;
    endproperty
    a_lpr: assert property (p_lpr) else $error("power limit not applied"); // RULE7

    property p_presence;
        !presence_n_oe_n && !presence_n_out;
    endproperty
    a_presence: assert property (p_presence) else $error("presence released"); // RULE8

    property p_fault;
        (en && fault_event && q.state == pmc_pkg::PMC_ST_READY && !d.defaults_pulse)
            |=> !attention_n_oe_n;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not flagged"); // RULE9

    property p_open_drain;
        !attention_n_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("attention driven high"); // RULE11

    property p_channels;
        q.state != pmc_pkg::PMC_ST_READY |-> tx_channel_enable == '0;
    endproperty
    a_channels: assert property (p_channels) else $error("channel on outside ready"); // RULE12

    property p_init_bound;
        q.state == pmc_pkg::PMC_ST_INIT |-> q.cnt <= INIT_LAST;
    endproperty
    a_init_bound: assert property (p_init_bound) else $error("init overran"); // RULE14

    property p_filter;
        q.defaults_pulse |-> $past(q.rst_cnt) == RST_LAST;
    endproperty
    a_filter: assert property (p_filter) else $error("short reset taken"); // RULE15

endmodule

// *** dv/pmc_host.sv ***
// Host board model: pull-ups and a framed serial clock
`timescale 1ns/1ps
module pmc_host
(
    input wire logic frame_on,
    input wire logic attention_n_out,
    input wire logic attention_n_oe_n,
    input wire logic presence_n_out,
    input wire logic presence_n_oe_n,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    output logic scl,
    output logic attention_n,
    output logic presence_n,
    output logic sda
);
    // ----------------
    // Wire levels
    // ----------------
    // Board pull-ups win whenever the module lets go
    assign attention_n = attention_n_oe_n ? 1'h1 : attention_n_out;
    assign presence_n = presence_n_oe_n ? 1'h1 : presence_n_out;
    assign sda = sda_oe_n ? 1'h1 : sda_out;
    // Clock stands high between frames; phase free of the core clock
    initial
    begin
        scl = 1'h1;
        #3.7;
        forever #6 scl = frame_on ? ~scl : 1'h1;
    end
endmodule

// *** dv/tb_pmc_ctrl.sv ***
// Self-checking bench of the pluggable module control core
`timescale 1ns/1ps
module tb_pmc_ctrl;
    // ----------------
    // Signals
    // ----------------
    logic clock = 1'h0, nrst = 1'h0, frame_on = 1'h0, en = 1'h1;
    logic sel_n = 1'h1, rst_n = 1'h1, lpr = 1'h0, sda_low = 1'h0, fault = 1'h0, ack = 1'h0;
    logic [3:0] ch_dis = 4'h0;
    logic scl, att_w, prs_w, sda_w, sda_o, sda_oe_n, slv_en, prs_o, prs_oe_n;
    logic att_o, att_oe_n, init_p, restore, pwr;
    logic [3:0] tx_en, ex;
    int error_cnt = 0, tests_run = 0, pulses = 0;
    logic [31:0] seed = 32'h8635BC55;
    string q_nm[$];
    logic [3:0] q_ex[$];
    string nm;
    event look;

    // Core clock, 25 ns period
    always #12.5 clock = ~clock;

    pmc_ctrl #(.INIT_CYCLES(20), .RST_MIN_CYCLES(16'h0004)) i_dut
    (
        .clock(clock), .nrst(nrst), .en(en), .scl(scl), .module_select_n(sel_n),
        .module_reset_n(rst_n), .low_power_request(lpr), .slave_sda_low(sda_low),
        .channel_disable(ch_dis), .fault_event(fault), .int_ack(ack), .sda_out(sda_o),
        .sda_oe_n(sda_oe_n), .slave_enable(slv_en), .presence_n_out(prs_o),
        .presence_n_oe_n(prs_oe_n), .attention_n_out(att_o), .attention_n_oe_n(att_oe_n),
        .init_pending_flag(init_p), .defaults_restore(restore), .power_limit_low(pwr),
        .tx_channel_enable(tx_en)
    );

    pmc_host i_host
    (
        .frame_on(frame_on), .attention_n_out(att_o), .attention_n_oe_n(att_oe_n),
        .presence_n_out(prs_o), .presence_n_oe_n(prs_oe_n), .sda_out(sda_o),
        .sda_oe_n(sda_oe_n), .scl(scl), .attention_n(att_w), .presence_n(prs_w), .sda(sda_w)
    );

    // ----------------
    // Scoreboard
    // ----------------
    // Restore is a one-cycle pulse, so it is counted rather than sampled
    always @(posedge clock)
        if (restore === 1'h1)
            pulses <= pulses + 1;

    function automatic logic [3:0] seen(string n);
        case (n)
            "init": return {3'h0, init_p};
            "att": return {3'h0, att_oe_n};
            "attw": return {3'h0, att_w};
            "prs": return {3'h0, prs_w};
            "pwr": return {3'h0, pwr};
            "sda": return {3'h0, sda_oe_n};
            "sen": return {3'h0, slv_en};
            "rst": return pulses[3:0];
            "tx": return tx_en;
            default: return 4'hX;
        endcase
    endfunction

    task automatic check(string n, logic [3:0] s, logic [3:0] e);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    // Loop drains every note pushed in the same time step
    always @(look)
        while (q_nm.size() > 0)
        begin
            nm = q_nm.pop_front();
            ex = q_ex.pop_front();
            check(nm, seen(nm), ex);
        end

    task automatic note(string n, logic [3:0] e);
        q_nm.push_back(n);
        q_ex.push_back(e);
        ->look;
    endtask

    // Inputs move 2 ns after the edge, outputs are settled by then
    task automatic cyc(int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (init_p !== 1'h0 && n < 100)
        begin
            cyc(1);
            n++;
        end
        if (init_p !== 1'h0)
        begin
            error_cnt++;
            results();
        end
    endtask

    task automatic ack_it();
        ack = 1'h1;
        cyc(1);
        ack = 1'h0;
        cyc(1);
    endtask

    // ----------------
    // Sequence
    // ----------------
    initial
    begin
        cyc(20);
        note("init", 4'h1);
        note("att", 4'h1);
        note("tx", 4'h0);
        nrst = 1'h1;
        wait_ready();
        note("att", 4'h0);
        note("attw", 4'h0);
        note("prs", 4'h0);
        $display("power-up done");
        ack_it();
        note("attw", 4'h1);
        fault = 1'h1;
        cyc(1);
        fault = 1'h0;
        note("att", 4'h0);
        cyc(3);
        note("att", 4'h0);
        ack_it();
        note("att", 4'h1);
        $display("attention done");
        for (int i = 0; i < 6; i++)
        begin
            seed = xs(seed);
            ch_dis = seed[3:0];
            cyc(1);
            note("tx", ~seed[3:0]);
        end
        for (int v = 1; v >= 0; v--)
        begin
            lpr = v[0];
            cyc(3);
            note("pwr", {3'h0, v[0]});
        end
        $display("lanes and power done");
        // Enable low freezes flags and lanes
        en = 1'h0;
        fault = 1'h1;
        ch_dis = ~ch_dis;
        cyc(2);
        note("att", 4'h1);
        note("tx", ch_dis);
        fault = 1'h0;
        ch_dis = ~ch_dis;
        en = 1'h1;
        cyc(1);
        $display("enable done");
        // Selected, then deselected: engine and data drive follow the select
        for (int v = 0; v < 2; v++)
        begin
            sel_n = v[0];
            sda_low = 1'h1;
            cyc(4);
            frame_on = 1'h1;
            cyc(4);
            note("sen", {3'h0, ~v[0]});
            note("sda", {3'h0, v[0]});
            frame_on = 1'h0;
            cyc(2);
        end
        sda_low = 1'h0;
        $display("select done");
        // Short pulse is filtered, long one restores defaults
        rst_n = 1'h0;
        cyc(3);
        rst_n = 1'h1;
        cyc(6);
        note("rst", 4'h0);
        rst_n = 1'h0;
        cyc(8);
        note("rst", 4'h1);
        note("init", 4'h1);
        note("tx", 4'h0);
        note("att", 4'h1);
        rst_n = 1'h1;
        wait_ready();
        note("att", 4'h0);
        // Lanes follow one edge after the ready state is entered
        cyc(1);
        note("tx", ~ch_dis);
        $display("reset done");
        cyc(2);
        results();
    end
endmodule
